// ==== hdl/bsil_core.sv ====
// file holds the boundary-scan instruction register and data path selection
//
// What this block does
// - three-bit instruction shift register, three latches
// - latches load only in update-ir or test-logic-reset state
// - test-logic-reset presets latches to bypass
// - decode extest, sample, hi-z, bypass codes
// - capture-ir loads 01 and crystal loss
// - capture-ir leaves latched instruction unchanged
// - crystal mode reports loss when no clock
// - external clock mode reports loss zero
// - extest links 132-bit boundary register
// - extest holds system logic in reset
// - extest drives, captures, steers boundary pins
// - sample captures pin snapshot in capture-dr
// - sampling and shifting leave pins undisturbed
`timescale 1ns/1ps
module bsil_core
    import bsil_pkg::*;
#(
    parameter int BSR_LEN = bsil_pkg::BSIL_BSR_LEN,
    parameter int FIFO_DEPTH = bsil_pkg::BSIL_FIFO_DEPTH
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // test port pins, asynchronous
    input wire logic tck_i,
    input wire logic tdi_i,
    input wire bsil_pkg::bsil_tap_s tap_i,
    output logic tdo_o,
    // clock source status
    input wire logic crystal_mode_i,
    input wire logic osc_clock_seen_i,
    // pins and system logic
    input wire logic [BSR_LEN-1:0] pin_in_i,
    input wire logic [BSR_LEN-1:0] sys_out_i,
    input wire logic [BSR_LEN-1:0] sys_oe_i,
    output logic [BSR_LEN-1:0] pin_out_o,
    output logic [BSR_LEN-1:0] pin_oe_o,
    output logic sys_reset_o,
    // decoded instruction
    output bsil_pkg::bsil_instr_e instr_o,
    // scan-out stream
    output logic scan_valid_o,
    input wire logic scan_ready_i,
    output logic scan_data_o
);
    import bsil_pkg::*;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    function automatic bsil_instr_e decode(input logic [2:0] c);
        bsil_instr_e r;
        r = BSIL_I_BYPASS;
        if (c == BSIL_OP_EXTEST) begin
            r = BSIL_I_EXTEST;
        end else if (c == BSIL_OP_SAMPLE) begin
            r = BSIL_I_SAMPLE;
        end else if (c == BSIL_OP_HIZ) begin
            r = BSIL_I_HIZ;
        end
        return r;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam int SYNW = 5 + $bits(bsil_tap_s);
    typedef struct packed {
        logic [SYNW-1:0] s1;
        logic [SYNW-1:0] s2;
        logic tck_d;
        logic [BSR_LEN-1:0] pin_s1;
        logic [BSR_LEN-1:0] pin_s2;
        logic [BSIL_IR_W-1:0] ir_sh;
        logic [BSIL_IR_W-1:0] ir_par;
        logic byp;
        logic [BSR_LEN-1:0] bsr_sh;
        logic [BSR_LEN-1:0] bsr_upd;
        logic tdo;
        logic push;
        logic push_bit;
    } bsil_state_s;

    bsil_state_s q;
    bsil_state_s next_q;
    logic fifo_in_ready;

    logic tck_s;
    logic tdi_s;
    logic xtal_s;
    logic seen_s;
    bsil_tap_s tap_s;
    logic rise;
    logic fall;
    logic crystal_loss_flag;
    bsil_instr_e cur;
    logic bsr_sel;

    assign {tck_s, tdi_s, xtal_s, seen_s, tap_s} = q.s2[SYNW-1:1];
    assign rise = tck_s && !q.tck_d;
    assign fall = !tck_s && q.tck_d;
    // crystal loss when no oscillator seen
    assign crystal_loss_flag = xtal_s && !seen_s;
    assign cur = decode(q.ir_par);
    // extest and sample choose boundary register
    // hi-z falls through to bypass bit
    assign bsr_sel = (cur == BSIL_I_EXTEST) || (cur == BSIL_I_SAMPLE);

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        next_q = q;
        next_q.push = 1'b0;
        next_q.s1 = {tck_i, tdi_i, crystal_mode_i, osc_clock_seen_i,
                     tap_i, 1'b0};
        next_q.s2 = q.s1;
        next_q.tck_d = tck_s;
        // pin levels cross in through two flops like the test port
        next_q.pin_s1 = pin_in_i;
        next_q.pin_s2 = q.pin_s1;
        if (rise) begin
            if (tap_s.test_reset) begin
                next_q.ir_par = BSIL_IR_RESET;
            end else if (tap_s.capture_ir) begin
                next_q.ir_sh = {crystal_loss_flag, BSIL_IR_CAPT_LOW};
            end else if (tap_s.shift_ir) begin
                next_q.ir_sh = {tdi_s, q.ir_sh[BSIL_IR_W-1:1]};
            end else if (tap_s.update_ir) begin
                next_q.ir_par = q.ir_sh;
            end
            if (tap_s.capture_dr) begin
                next_q.byp = BSIL_BYP_CAPT;
                // snapshot of pins on tck rise
                if (bsr_sel) begin
                    next_q.bsr_sh = q.pin_s2;
                end
            end else if (tap_s.shift_dr) begin
                next_q.byp = tdi_s;
                if (bsr_sel) begin
                    next_q.bsr_sh = {tdi_s, q.bsr_sh[BSR_LEN-1:1]};
                    next_q.push = 1'b1;
                    next_q.push_bit = q.bsr_sh[0];
                end
            end else if (tap_s.update_dr && bsr_sel) begin
                next_q.bsr_upd = q.bsr_sh;
            end
        end
        // tdo changes on falling tck as the scan standard expects
        if (fall) begin
            // capture counts too: bit 0 must stand before the first shift
            if (tap_s.capture_ir || tap_s.shift_ir) begin
                next_q.tdo = q.ir_sh[0];
            end else if (bsr_sel) begin
                next_q.tdo = q.bsr_sh[0];
            end else begin
                next_q.tdo = q.byp;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.ir_par <= BSIL_IR_RESET;
        end else begin
            q <= next_q;
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    always_comb begin
        unique case (cur)
            BSIL_I_EXTEST: begin
                pin_out_o = q.bsr_upd;
                pin_oe_o = sys_oe_i & q.bsr_upd;
            end
            BSIL_I_HIZ: begin
                pin_out_o = sys_out_i;
                pin_oe_o = '0;
            end
            BSIL_I_SAMPLE, BSIL_I_BYPASS: begin
                pin_out_o = sys_out_i;
                pin_oe_o = sys_oe_i;
            end
        endcase
    end

    assign sys_reset_o = (cur == BSIL_I_EXTEST);
    assign instr_o = cur;
    assign tdo_o = q.tdo;

    // observer stream; a stalled drain only drops bits, never the scan
    bsil_fifo #(.WIDTH(1), .DEPTH(FIFO_DEPTH)) u_fifo (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(q.push && fifo_in_ready),
        .in_ready_o(fifo_in_ready),
        .in_data_i(q.push_bit),
        .out_valid_o(scan_valid_o),
        .out_ready_i(scan_ready_i),
        .out_data_o(scan_data_o)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // preset on reset
    tlr_preset_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && tap_s.test_reset |=> q.ir_par == BSIL_IR_RESET)
        else $error("instruction not preset to bypass");
    par_hold_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        !(rise && (tap_s.update_ir || tap_s.test_reset))
        |=> $stable(q.ir_par))
        else $error("instruction latch changed outside update");
    par_load_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && $onehot(tap_s) && tap_s.update_ir
        |=> q.ir_par == $past(q.ir_sh))
        else $error("instruction latch not loaded in update");
    ir_shift_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && $onehot(tap_s) && tap_s.shift_ir
        |=> q.ir_sh == {$past(tdi_s), $past(q.ir_sh[BSIL_IR_W-1:1])})
        else $error("instruction shift wrong");
    capt_ir_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && tap_s.capture_ir && !tap_s.test_reset
        |=> q.ir_sh == {$past(crystal_loss_flag), BSIL_IR_CAPT_LOW})
        else $error("capture-ir pattern wrong");
    capt_keep_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && tap_s.capture_ir && !tap_s.test_reset |=> $stable(q.ir_par))
        else $error("capture-ir moved the instruction latch");
    xtal_loss_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && $onehot(tap_s) && tap_s.capture_ir && xtal_s
        |=> q.ir_sh[BSIL_IR_W-1] == !$past(seen_s))
        else $error("crystal loss flag wrong");
    ext_loss_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && $onehot(tap_s) && tap_s.capture_ir && !xtal_s
        |=> !q.ir_sh[BSIL_IR_W-1])
        else $error("loss flag set with external clock");
    dec_samp_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        q.ir_par == BSIL_OP_SAMPLE |-> instr_o == BSIL_I_SAMPLE)
        else $error("sample code decoded wrongly");
    ext_reset_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (q.ir_par == BSIL_OP_EXTEST) |-> sys_reset_o)
        else $error("system not held in reset under extest");
    hiz_float_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (q.ir_par == BSIL_OP_HIZ) |-> (pin_oe_o == '0) && !bsr_sel)
        else $error("outputs driven under hi-z");
    byp_zero_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && tap_s.capture_dr |=> q.byp == 1'b0)
        else $error("bypass bit did not capture zero");
    snap_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && tap_s.capture_dr && bsr_sel |=> q.bsr_sh == $past(q.pin_s2))
        else $error("pin snapshot not captured");
    samp_pins_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        (cur == BSIL_I_SAMPLE) |-> pin_oe_o == sys_oe_i && !sys_reset_o
        && pin_out_o == sys_out_i)
        else $error("sample disturbed pins");
    bsr_tdo_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        fall && $onehot(tap_s) && tap_s.shift_dr && cur == BSIL_I_EXTEST
        |=> q.tdo == $past(q.bsr_sh[0]))
        else $error("boundary bit not presented on tdo");
    ext_drive_a: assert property (
        @(posedge ref_clk_i) disable iff (!rstn_i)
        rise && $onehot(tap_s) && tap_s.update_dr && cur == BSIL_I_EXTEST
        |=> pin_out_o == $past(q.bsr_sh))
        else $error("extest pins not driven from update cells");
endmodule

// ==== hdl/bsil_pkg.sv ====
// package: constants and carrier types for the boundary-scan instruction logic
package bsil_pkg;
    localparam int BSIL_IR_W = 3;
    localparam int BSIL_BSR_LEN = 132;
    localparam int BSIL_FIFO_DEPTH = 32;
    localparam logic [2:0] BSIL_IR_RESET = 3'h7;
    localparam logic [1:0] BSIL_IR_CAPT_LOW = 2'h1;
    localparam logic [2:0] BSIL_OP_EXTEST = 3'h0;
    localparam logic [2:0] BSIL_OP_SAMPLE = 3'h1;
    localparam logic [2:0] BSIL_OP_HIZ = 3'h4;
    localparam logic BSIL_BYP_CAPT = 1'h0;

    typedef enum logic [1:0] {
        BSIL_I_EXTEST,
        BSIL_I_SAMPLE,
        BSIL_I_BYPASS,
        BSIL_I_HIZ
    } bsil_instr_e;

    // controller state phases presented by the tap sequencer
    typedef struct packed {
        logic test_reset;
        logic capture_ir;
        logic shift_ir;
        logic update_ir;
        logic capture_dr;
        logic shift_dr;
        logic update_dr;
    } bsil_tap_s;

    // one boundary cell group: pin input and system output data
    typedef struct packed {
        logic [BSIL_BSR_LEN-1:0] pin_in;
        logic [BSIL_BSR_LEN-1:0] sys_out;
    } bsil_pins_s;
endpackage

// ==== hdl/bsil_fifo.sv ====
// file holds the fifo for captured scan-out bits
`timescale 1ns/1ps
module bsil_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // write side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // read side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic full;
    logic empty;
    assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
    assign empty = (wp == rp);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem[rp[AW-1:0]];
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wp <= '0;
            rp <= '0;
        end else begin
            if (in_valid_i && !full) begin
                mem[wp[AW-1:0]] <= in_data_i;
                wp <= wp + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rp <= rp + 1'b1;
            end
        end
    end
endmodule

// ==== sim/bsil_tap_model.sv ====
// tap controller model that drives the test port pins
`timescale 1ns/1ps
module bsil_tap_model (
    // clock
    input wire logic ref_clk_i,
    // test port
    output logic tck_o,
    output logic tdi_o,
    output bsil_pkg::bsil_tap_s tap_o,
    input wire logic tdo_i
);
    import bsil_pkg::*;
    localparam int N = BSIL_BSR_LEN;
    initial begin
        tck_o <= 1'b0;
        tdi_o <= 1'b0;
        tap_o <= '0;
    end
    // -------------------------------------------------------------
    // tck periods of 8 clocks; tck stands low between scans
    // -------------------------------------------------------------
    // tester shifts out
    // flags and tdi move only while tck is low; tdo read late in high
    task automatic pulse(input logic [6:0] st, input logic d, output logic q);
        @(posedge ref_clk_i);
        tap_o <= bsil_tap_s'(st);
        tdi_o <= d;
        repeat (3) @(posedge ref_clk_i);
        tck_o <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        q = tdo_i;
        @(posedge ref_clk_i);
        tck_o <= 1'b0;
        // a released tdi shows the inverse so a stale bit never passes
        tdi_o <= ~d;
    endtask
    task automatic scan(input logic [6:0] cap, input logic [6:0] sh,
            input int n, input logic [N-1:0] din, output logic [N-1:0] dout);
        logic q;
        dout = '0;
        pulse(cap, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            pulse(sh, din[i], q);
            dout[i] = q;
        end
    endtask
    task automatic ir_shift(input logic [2:0] c, output logic [N-1:0] o);
        scan(7'h20, 7'h10, 3, N'(c), o);
    endtask
    task automatic ir_update();
        logic q;
        pulse(7'h08, 1'b0, q);
    endtask
    task automatic tap_reset();
        logic q;
        pulse(7'h40, 1'b0, q);
    endtask
    task automatic dr_scan(input int n, input logic [N-1:0] din,
            output logic [N-1:0] o);
        logic q;
        scan(7'h04, 7'h02, n, din, o);
        pulse(7'h01, 1'b0, q);
    endtask
endmodule

// ==== sim/tb_boundary_scan_instruction_logic.sv ====
// self-checking bench for the boundary-scan instruction logic
`timescale 1ns/1ps
module tb_boundary_scan_instruction_logic;
    import bsil_pkg::*;
    localparam int N = BSIL_BSR_LEN;
    localparam logic [N-1:0] PAT_A = {4'h9, {4{32'hA5C30F96}}};
    localparam logic [N-1:0] PAT_B = {4'h6, {4{32'h3C5AE187}}};
    logic ref_clk_i, rstn_i, tck, tdi, tdo, xtal, osc, sys_reset;
    logic scan_valid, scan_ready, scan_data;
    logic [N-1:0] pin_in, sys_out, sys_oe, pin_out, pin_oe, o;
    bsil_tap_s tap;
    bsil_instr_e instr;
    int bad_count, checks;
    bsil_core #(.BSR_LEN(N), .FIFO_DEPTH(BSIL_FIFO_DEPTH)) dut (
        .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .tck_i(tck), .tdi_i(tdi),
        .tap_i(tap), .tdo_o(tdo), .crystal_mode_i(xtal),
        .osc_clock_seen_i(osc), .pin_in_i(pin_in), .sys_out_i(sys_out),
        .sys_oe_i(sys_oe), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .sys_reset_o(sys_reset), .instr_o(instr), .scan_valid_o(scan_valid),
        .scan_ready_i(scan_ready), .scan_data_o(scan_data));
    bsil_tap_model u_tap (.ref_clk_i(ref_clk_i), .tck_o(tck), .tdi_o(tdi),
        .tap_o(tap), .tdo_i(tdo));
    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------
    task automatic chk(input logic [N-1:0] g, input logic [N-1:0] e,
            input string w);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %0t %s", $time, w);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic ld(input logic [2:0] c);
        u_tap.ir_shift(c, o);
        u_tap.ir_update();
        repeat (4) @(posedge ref_clk_i);
    endtask
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    task automatic t_decode();
        bsil_instr_e e, p;
        p = BSIL_I_BYPASS;
        chk(N'(instr), N'(p), "reset instr");
        for (int c = 0; c < 8; c++) begin
            e = c == 0 ? BSIL_I_EXTEST : c == 1 ? BSIL_I_SAMPLE :
                c == 4 ? BSIL_I_HIZ : BSIL_I_BYPASS;
            u_tap.ir_shift(3'(c), o);
            chk(o, N'(3'h1), "ir capture");
            chk(N'(instr), N'(p), "instr moved early");
            u_tap.ir_update();
            repeat (4) @(posedge ref_clk_i);
            chk(N'(instr), N'(e), "decode");
            chk(N'(sys_reset), N'(c == 0), "sys reset");
            p = e;
        end
        ld(3'h0);
        u_tap.tap_reset();
        repeat (4) @(posedge ref_clk_i);
        chk(N'(instr), N'(BSIL_I_BYPASS), "tap reset");
        $display("test decode done");
    endtask
    task automatic t_loss();
        for (int i = 0; i < 4; i++) begin
            xtal <= i[1];
            osc <= i[0];
            repeat (4) @(posedge ref_clk_i);
            ld(3'h7);
            chk(o, N'({i == 2, 2'h1}), "loss flag");
        end
        $display("test loss done");
    endtask
    task automatic t_extest();
        logic [N-1:0] g;
        int n;
        g = '0;
        n = 0;
        ld(3'h0);
        pin_in <= PAT_A;
        sys_oe <= PAT_A;
        scan_ready <= 1'b0;
        u_tap.dr_scan(N, PAT_B, o);
        repeat (4) @(posedge ref_clk_i);
        chk(o, PAT_A, "extest capture");
        chk(pin_out, PAT_B, "extest drive");
        chk(pin_oe, PAT_A & PAT_B, "extest enable");
        chk(N'(sys_reset), N'(1'b1), "extest reset");
        scan_ready <= 1'b1;
        for (int i = 0; i < 100; i++) begin
            @(posedge ref_clk_i);
            if (scan_valid === 1'b1 && scan_ready === 1'b1 && n < N) begin
                g[n] = scan_data;
                n++;
            end
        end
        chk(N'(n), N'(BSIL_FIFO_DEPTH), "fifo count");
        chk(g, N'(PAT_A[BSIL_FIFO_DEPTH-1:0]), "fifo data");
        $display("test extest done");
    endtask
    task automatic t_sample();
        ld(3'h1);
        pin_in <= PAT_B;
        sys_out <= PAT_A;
        sys_oe <= ~PAT_A;
        u_tap.dr_scan(N, PAT_A, o);
        repeat (4) @(posedge ref_clk_i);
        chk(o, PAT_B, "snapshot");
        chk(pin_out, PAT_A, "pins disturbed");
        chk(pin_oe, ~PAT_A, "enables disturbed");
        chk(N'(sys_reset), N'(1'b0), "sample reset");
        $display("test sample done");
    endtask
    task automatic t_bypass();
        for (int k = 0; k < 2; k++) begin
            ld(k == 0 ? 3'h2 : 3'h4);
            u_tap.dr_scan(4, N'(4'hB), o);
            chk(o, N'(4'h6), "bypass bit");
        end
        chk(pin_oe, '0, "hi-z enables");
        $display("test bypass done");
    endtask
    initial begin
        ref_clk_i = 1'b0;
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        bad_count++;
        $display("BAD %0t timeout", $time);
        end_sim();
    end
    initial begin
        {rstn_i, xtal, osc, scan_ready} <= 4'h3;
        {pin_in, sys_out, sys_oe} <= {PAT_A, PAT_B, ~PAT_B};
        repeat (12) @(posedge ref_clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        t_decode();
        t_loss();
        t_extest();
        t_sample();
        t_bypass();
        end_sim();
    end
endmodule
